//--- include/shifter_norm_pkg.sv
// Package of constants and types for the shifter normalize unit
package shifter_norm_pkg;

  // Data widths
  localparam int WORD_W = 16;
  localparam int CODE_W = 8;
  localparam int RESULT_W = 40;
  localparam int EXT_W = 8;
  localparam int COUNT_W = 5;
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;

  // Register byte offsets on the bus
  localparam logic [WB_ADR_W-1:0] OFS_OPERAND = 8'h00;
  localparam logic [WB_ADR_W-1:0] OFS_FLAGS = 8'h04;
  localparam logic [WB_ADR_W-1:0] OFS_EXPONENT = 8'h08;
  localparam logic [WB_ADR_W-1:0] OFS_RES_BOTTOM = 8'h0C;
  localparam logic [WB_ADR_W-1:0] OFS_RES_MIDDLE = 8'h10;
  localparam logic [WB_ADR_W-1:0] OFS_RES_EXT = 8'h14;
  localparam logic [WB_ADR_W-1:0] OFS_COMMAND = 8'h18;
  localparam logic [WB_ADR_W-1:0] OFS_STATUS = 8'h1C;

  // Flag register bit positions
  localparam int FLAG_OVERFLOW_BIT = 0;
  localparam int FLAG_CARRY_BIT = 1;

  // Status register bit positions
  localparam int STAT_SIGN_BIT = 0;
  localparam int STAT_RES_OVF_BIT = 1;

  // Exponent values with special meaning
  localparam logic [WORD_W-1:0] EXP_PLUS_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] EXP_ALL_SIGN = 16'hFFF1;
  localparam logic [CODE_W-1:0] CODE_PLUS_ONE = 8'h01;
  localparam logic [COUNT_W+1:0] LOW_EXP_BASE = 7'h0F;

  // Shift placement constants
  localparam logic signed [9:0] HI_REF_SHIFT = 10'sh010;
  localparam logic [5:0] MAX_LEFT = 6'h28;
  localparam logic [5:0] MAX_RIGHT = 6'h38;

  // Reset values
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [RESULT_W-1:0] RST_RESULT = 40'h00_0000_0000;

  // Operation kinds and reference modes
  typedef enum logic {
    OP_DERIVE = 1'b0,
    OP_ALIGN = 1'b1
  } op_kind_t;

  typedef enum logic [1:0] {
    REF_UPPER = 2'h0,
    REF_LOWER = 2'h1,
    REF_OVF_AWARE = 2'h2,
    REF_SPARE = 2'h3
  } ref_mode_t;

  // Command word as written to the command register, bits [3:0]
  typedef struct packed {
    logic merge;
    ref_mode_t ref_mode;
    op_kind_t op;
  } cmd_t;

  localparam int CMD_W = 4;
  localparam cmd_t RST_CMD = '{merge: 1'b0, ref_mode: REF_UPPER, op: OP_DERIVE};

endpackage

//--- rtl/sign_count.sv
// Counts leading bits equal to a reference sign, from the MSB down
module sign_count (
  // Operand and the sign it is compared with
  input wire logic [shifter_norm_pkg::WORD_W-1:0] operand_i,
  input wire logic sign_i,
  // Number of leading matching bits, 0 to 16
  output logic [shifter_norm_pkg::COUNT_W-1:0] count_o
);
  import shifter_norm_pkg::*;

  logic [WORD_W-1:0] prefix;

  // Each bit is set while every bit above it also matches the sign
  assign prefix[WORD_W-1] = (operand_i[WORD_W-1] == sign_i);
  genvar i;
  generate
    // Ascending loop keeps the genvar non-negative; assignment order is irrelevant
    for (i = 0; i < WORD_W - 1; i++) begin : g_prefix
      assign prefix[i] = prefix[i+1] & (operand_i[i] == sign_i);
    end
  endgenerate

  // Population count of the prefix mask
  always_comb begin
    count_o = '0;
    for (int k = 0; k < WORD_W; k++) begin
      count_o = count_o + {{(COUNT_W-1){1'b0}}, prefix[k]};
    end
  end

endmodule

//--- rtl/barrel_place.sv
// Places a 16-bit operand anywhere in the 40-bit result field
module barrel_place (
  // Operand, signed shift code and placement options
  input wire logic [shifter_norm_pkg::WORD_W-1:0] operand_i,
  input wire logic [shifter_norm_pkg::CODE_W-1:0] code_i,
  input wire logic ref_lower_i,
  input wire logic ext_i,
  // Placed value
  output logic [shifter_norm_pkg::RESULT_W-1:0] placed_o
);
  import shifter_norm_pkg::*;

  logic [2*RESULT_W-1:0] wide;
  logic [3*RESULT_W+WORD_W-1:0] right_full;
  logic signed [9:0] amt;
  logic [5:0] left_amt;
  logic [5:0] right_amt;
  logic [9:0] neg_amt;

  // Operand sits just above the field's zero fill, extension bits above it
  assign wide = {{(RESULT_W-WORD_W){ext_i}}, operand_i, {RESULT_W{1'b0}}};

  // Upper reference adds one word of upshift so code 0 lands in the middle word
  assign amt = $signed({{2{code_i[CODE_W-1]}}, code_i}) + (ref_lower_i ? 10'sh000 : HI_REF_SHIFT);
  assign neg_amt = 10'(-amt);

  // Clamp: beyond these amounts the field is all zero or all extension
  always_comb begin
    left_amt = '0;
    right_amt = '0;
    if (!amt[9]) begin
      left_amt = (amt > $signed({4'h0, MAX_LEFT})) ? MAX_LEFT : amt[5:0];
    end else begin
      right_amt = (neg_amt > {4'h0, MAX_RIGHT}) ? MAX_RIGHT : neg_amt[5:0];
    end
  end

  // Right shifts pull extension bits in from the left
  assign right_full = {{(RESULT_W+WORD_W){ext_i}}, wide} >> right_amt;

  always_comb begin
    if (!amt[9]) begin
      placed_o = wide[2*RESULT_W-1-left_amt -: RESULT_W];
    end else begin
      placed_o = right_full[2*RESULT_W-1:RESULT_W];
    end
  end

endmodule

//--- rtl/shifter_normalize_unit.sv
// Shifter normalize unit: exponent derivation and alignment behind a Wishbone slave
//
// Design decisions made here: the address map and the Wishbone slave port.
module shifter_normalize_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [shifter_norm_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [shifter_norm_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [shifter_norm_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o
);
  import shifter_norm_pkg::*;

  // Architectural state
  logic [WORD_W-1:0] alu_result_operand;
  logic alu_overflow_flag;
  logic alu_carry_flag;
  logic [WORD_W-1:0] shift_exponent_reg;
  logic [RESULT_W-1:0] result_accumulator;
  logic input_sign;
  cmd_t last_cmd;
  logic ack;
  logic [WB_DAT_W-1:0] rd_data;

  // Next values
  logic [WORD_W-1:0] next_alu_result_operand;
  logic next_alu_overflow_flag;
  logic next_alu_carry_flag;
  logic [WORD_W-1:0] next_shift_exponent_reg;
  logic [RESULT_W-1:0] next_result_accumulator;
  logic next_input_sign;
  cmd_t next_last_cmd;
  logic next_ack;
  logic [WB_DAT_W-1:0] next_rd_data;

  // Views of the result accumulator
  logic [WORD_W-1:0] result_bottom_word;
  logic [WORD_W-1:0] result_middle_word;
  logic [EXT_W-1:0] result_extension_word;
  logic result_overflow;

  // Bus decode
  logic bus_req;
  logic bus_commit;
  logic bus_write;
  logic [WB_DAT_W-1:0] wmask;
  cmd_t wr_cmd;

  // Datapath signals
  logic [COUNT_W-1:0] upper_count;
  logic [COUNT_W-1:0] lower_count;
  logic [WORD_W-1:0] upper_exp;
  logic [WORD_W-1:0] lower_exp;
  logic [COUNT_W+1:0] lower_mag;
  logic [CODE_W-1:0] align_code;
  logic align_lower;
  logic align_ext;
  logic [RESULT_W-1:0] placed;

  // Result word views
  assign result_bottom_word = result_accumulator[WORD_W-1:0];
  assign result_middle_word = result_accumulator[2*WORD_W-1:WORD_W];
  assign result_extension_word = result_accumulator[RESULT_W-1:2*WORD_W];

  // Result overflow: extension byte disagrees with middle word sign
  assign result_overflow = (result_extension_word != {EXT_W{result_middle_word[WORD_W-1]}});

  // A request is answered one cycle later; it takes effect on the acked edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_commit = bus_req & ack;
  assign bus_write = bus_commit & wb_we_i;

  // Byte lane mask from the selects
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
  endgenerate

  // Command taken from the low lane of the write data
  assign wr_cmd = cmd_t'(wb_dat_i[CMD_W-1:0]);

  // Upper half exponent: count of sign bits, one of which is not redundant
  sign_count u_upper_count (
    .operand_i(alu_result_operand),
    .sign_i(alu_result_operand[WORD_W-1]),
    .count_o(upper_count)
  );

  // Lower half is scanned against the sign kept from the upper half
  sign_count u_lower_count (
    .operand_i(alu_result_operand),
    .sign_i(input_sign),
    .count_o(lower_count)
  );

  // Exponent is minus the redundant sign count, sign-extended to 16 bits
  assign upper_exp = WORD_W'(1) - WORD_W'(upper_count);

  // Lower half continues the count from the fifteen already found
  assign lower_mag = LOW_EXP_BASE + (COUNT_W+2)'(lower_count);
  assign lower_exp = WORD_W'(0) - WORD_W'(lower_mag);

  // Only the low byte of the exponent steers the shift, negated for alignment
  assign align_code = CODE_W'(0) - shift_exponent_reg[CODE_W-1:0];
  assign align_lower = (wr_cmd.ref_mode == REF_LOWER);

  // Extension bit: zero below, carry when exponent is +1, else operand sign.
  // The overflow flag is not consulted here; a plain exponent load of +1
  // therefore also brings the carry in.
  always_comb begin
    if (align_lower) begin
      align_ext = 1'b0;
    end else if (shift_exponent_reg[CODE_W-1:0] == CODE_PLUS_ONE) begin
      align_ext = alu_carry_flag;
    end else begin
      align_ext = alu_result_operand[WORD_W-1];
    end
  end

  // Barrel placement of the operand into the 40-bit field
  barrel_place u_place (
    .operand_i(alu_result_operand),
    .code_i(align_code),
    .ref_lower_i(align_lower),
    .ext_i(align_ext),
    .placed_o(placed)
  );

  // Next state of the whole unit
  always_comb begin
    next_alu_result_operand = alu_result_operand;
    next_alu_overflow_flag = alu_overflow_flag;
    next_alu_carry_flag = alu_carry_flag;
    next_shift_exponent_reg = shift_exponent_reg;
    next_result_accumulator = result_accumulator;
    next_input_sign = input_sign;
    next_last_cmd = last_cmd;
    next_ack = bus_req & ~ack;
    next_rd_data = rd_data;

    // Read data is captured only for reads, so a write never disturbs the last value read
    if (bus_req && !ack && !wb_we_i) begin
      if (wb_adr_i == OFS_OPERAND) begin
        next_rd_data = {16'h0000, alu_result_operand};
      end else if (wb_adr_i == OFS_FLAGS) begin
        next_rd_data = '0;
        next_rd_data[FLAG_OVERFLOW_BIT] = alu_overflow_flag;
        next_rd_data[FLAG_CARRY_BIT] = alu_carry_flag;
      end else if (wb_adr_i == OFS_EXPONENT) begin
        next_rd_data = {16'h0000, shift_exponent_reg};
      end else if (wb_adr_i == OFS_RES_BOTTOM) begin
        next_rd_data = {16'h0000, result_bottom_word};
      end else if (wb_adr_i == OFS_RES_MIDDLE) begin
        next_rd_data = {16'h0000, result_middle_word};
      end else if (wb_adr_i == OFS_RES_EXT) begin
        next_rd_data = {24'h00_0000, result_extension_word};
      end else if (wb_adr_i == OFS_COMMAND) begin
        next_rd_data = {28'h000_0000, last_cmd};
      end else if (wb_adr_i == OFS_STATUS) begin
        next_rd_data = '0;
        next_rd_data[STAT_SIGN_BIT] = input_sign;
        next_rd_data[STAT_RES_OVF_BIT] = result_overflow;
      end else begin
        next_rd_data = '0;
      end
    end

    // Register writes, honouring byte lanes on the 16-bit registers
    if (bus_write) begin
      if (wb_adr_i == OFS_OPERAND) begin
        next_alu_result_operand = (alu_result_operand & ~wmask[WORD_W-1:0]) | (wb_dat_i[WORD_W-1:0] & wmask[WORD_W-1:0]);
      end else if (wb_adr_i == OFS_FLAGS) begin
        if (wb_sel_i[0]) begin
          next_alu_overflow_flag = wb_dat_i[FLAG_OVERFLOW_BIT];
          next_alu_carry_flag = wb_dat_i[FLAG_CARRY_BIT];
        end
      end else if (wb_adr_i == OFS_EXPONENT) begin
        next_shift_exponent_reg = (shift_exponent_reg & ~wmask[WORD_W-1:0]) | (wb_dat_i[WORD_W-1:0] & wmask[WORD_W-1:0]);
      end else if (wb_adr_i == OFS_RES_BOTTOM) begin
        next_result_accumulator[WORD_W-1:0] = (result_bottom_word & ~wmask[WORD_W-1:0]) | (wb_dat_i[WORD_W-1:0] & wmask[WORD_W-1:0]);
      end else if (wb_adr_i == OFS_RES_MIDDLE) begin
        next_result_accumulator[2*WORD_W-1:WORD_W] = (result_middle_word & ~wmask[WORD_W-1:0]) | (wb_dat_i[WORD_W-1:0] & wmask[WORD_W-1:0]);
      end else if (wb_adr_i == OFS_RES_EXT) begin
        if (wb_sel_i[0]) begin
          next_result_accumulator[RESULT_W-1:2*WORD_W] = wb_dat_i[EXT_W-1:0];
        end
      end else if (wb_adr_i == OFS_COMMAND && wb_sel_i[0]) begin
        // The command runs in this very cycle; its result is in place for the next access
        next_last_cmd = wr_cmd;
        if (wr_cmd.op == OP_DERIVE) begin
          // Derivation must precede alignment for a meaningful exponent
          case (wr_cmd.ref_mode)
            REF_OVF_AWARE: begin
              if (alu_overflow_flag) begin
                // Overflowed sum: exponent +1, the true sign is the inverted operand MSB
                next_shift_exponent_reg = EXP_PLUS_ONE;
                next_input_sign = ~alu_result_operand[WORD_W-1];
              end else begin
                next_shift_exponent_reg = upper_exp;
                next_input_sign = alu_result_operand[WORD_W-1];
              end
            end
            REF_LOWER: begin
              // Only an all-sign upper half leaves the exponent open
              if (shift_exponent_reg == EXP_ALL_SIGN) begin
                next_shift_exponent_reg = lower_exp;
              end
            end
            default: begin
              next_shift_exponent_reg = upper_exp;
              next_input_sign = alu_result_operand[WORD_W-1];
            end
          endcase
        end else begin
          // Alignment: overwrite, or OR into the previous half
          if (wr_cmd.merge) begin
            next_result_accumulator = result_accumulator | placed;
          end else begin
            next_result_accumulator = placed;
          end
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alu_result_operand <= RST_WORD;
      alu_overflow_flag <= 1'b0;
      alu_carry_flag <= 1'b0;
      shift_exponent_reg <= RST_WORD;
      result_accumulator <= RST_RESULT;
      input_sign <= 1'b0;
      last_cmd <= RST_CMD;
      ack <= 1'b0;
      rd_data <= '0;
    end else begin
      alu_result_operand <= next_alu_result_operand;
      alu_overflow_flag <= next_alu_overflow_flag;
      alu_carry_flag <= next_alu_carry_flag;
      shift_exponent_reg <= next_shift_exponent_reg;
      result_accumulator <= next_result_accumulator;
      input_sign <= next_input_sign;
      last_cmd <= next_last_cmd;
      ack <= next_ack;
      rd_data <= next_rd_data;
    end
  end

  // Bus outputs straight from flip-flops
  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;

endmodule

//--- tb/shifter_normalize_unit_asserts.sv
// Bus-level checker for the shifter normalize unit
module shifter_normalize_unit_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [shifter_norm_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [shifter_norm_pkg::WB_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import shifter_norm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A read taken at one edge and answered at the next
  sequence s_rd(logic [WB_ADR_W-1:0] a);
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a ##1 wb_ack_o;
  endsequence

  // Reset must clear the answer path, so the default disable is overridden here
  property p_rst_quiet;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == '0;
  endproperty
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_ext_width;
    s_rd(OFS_RES_EXT) |-> wb_dat_o[31:8] == '0;
  endproperty
  property p_mid_width;
    s_rd(OFS_RES_MIDDLE) |-> wb_dat_o[31:16] == '0;
  endproperty
  property p_exp_width;
    s_rd(OFS_EXPONENT) |-> wb_dat_o[31:16] == '0;
  endproperty
  // Read data may only move when a read is taken
  property p_dat_hold;
    !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o);
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("bus not quiet after reset");
  a_ack_next: assert property (p_ack_next) else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_ext_width: assert property (p_ext_width) else $error("extension word wider than 8 bits");
  a_mid_width: assert property (p_mid_width) else $error("middle word wider than 16 bits");
  a_exp_width: assert property (p_exp_width) else $error("exponent wider than 16 bits");
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without a read");
endmodule

bind shifter_normalize_unit shifter_normalize_unit_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

//--- tb/core_bus_master.sv
// Model of the core side: issues classic Wishbone accesses
module core_bus_master (
  // Clock and slave answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Request signals
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // One access; on release cyc, stb and we drop and address and data show inverted values so stale data never looks valid
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, we, a, 4'hF, d};
    // Hold the request until ack is seen; only the bench watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~d};
  endtask
endmodule

//--- tb/shifter_normalize_unit_tb.sv
// Self-checking bench for the shifter normalize unit
module shifter_normalize_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import shifter_norm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int errors = 0;
  int num_checks = 0;

  shifter_normalize_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  core_bus_master core (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // 250 MHz clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    core.xfer(1'b1, a, d, q);
  endtask

  function automatic cmd_t mk(input logic m, input ref_mode_t r, input op_kind_t o);
    return '{merge: m, ref_mode: r, op: o};
  endfunction

  // Load operand and flags {carry, overflow}, then fire one command
  task automatic op(input logic [15:0] v, input logic [1:0] f, input cmd_t c);
    wr(OFS_OPERAND, {16'h0000, v});
    wr(OFS_FLAGS, {30'h0, f});
    wr(OFS_COMMAND, {28'h0, c});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    core.xfer(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, e);
  endtask

  task automatic res(input logic [39:0] e);
    rd_chk("extension", OFS_RES_EXT, {24'h00_0000, e[39:32]});
    rd_chk("middle", OFS_RES_MIDDLE, {16'h0000, e[31:16]});
    rd_chk("bottom", OFS_RES_BOTTOM, {16'h0000, e[15:0]});
  endtask

  task automatic t_reset;
    rd_chk("exponent", OFS_EXPONENT, 32'h0000_0000);
    rd_chk("command", OFS_COMMAND, 32'h0000_0000);
    res(40'h00_0000_0000);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
  endtask

  task automatic t_single;
    op(16'hF6D4, 2'b00, mk(1'b0, REF_UPPER, OP_DERIVE));
    rd_chk("exponent", OFS_EXPONENT, 32'h0000_FFFD);
    op(16'hF6D4, 2'b00, mk(1'b0, REF_UPPER, OP_ALIGN));
    res(40'hFF_B6A0_0000);
    op(16'hF6D4, 2'b00, mk(1'b0, REF_LOWER, OP_ALIGN));
    res(40'h00_0007_B6A0);
  endtask

  task automatic t_ovf;
    op(16'hFA32, 2'b01, mk(1'b0, REF_OVF_AWARE, OP_DERIVE));
    rd_chk("exponent", OFS_EXPONENT, 32'h0000_0001);
    // Kept sign is the inverted operand MSB; result so far has no overflow
    rd_chk("status", OFS_STATUS, 32'h0000_0000);
    op(16'hFA32, 2'b01, mk(1'b0, REF_UPPER, OP_ALIGN));
    res(40'h00_7D19_0000);
    op(16'hE35B, 2'b10, mk(1'b0, REF_OVF_AWARE, OP_DERIVE));
    rd_chk("exponent", OFS_EXPONENT, 32'h0000_FFFE);
    rd_chk("status", OFS_STATUS, 32'h0000_0001);
    // Exponent loaded directly: carry must enter without the overflow flag
    wr(OFS_EXPONENT, 32'h0000_0001);
    op(16'h1234, 2'b10, mk(1'b0, REF_UPPER, OP_ALIGN));
    res(40'hFF_891A_0000);
  endtask

  task automatic t_double;
    op(16'hF6D4, 2'b00, mk(1'b0, REF_UPPER, OP_DERIVE));
    op(16'h6ECB, 2'b00, mk(1'b0, REF_LOWER, OP_DERIVE));
    rd_chk("exponent", OFS_EXPONENT, 32'h0000_FFFD);
    op(16'hF6D4, 2'b00, mk(1'b0, REF_UPPER, OP_ALIGN));
    op(16'h6ECB, 2'b00, mk(1'b1, REF_LOWER, OP_ALIGN));
    res(40'hFF_B6A3_7658);
    op(16'h6ECB, 2'b00, mk(1'b0, REF_LOWER, OP_ALIGN));
    op(16'hF6D4, 2'b00, mk(1'b1, REF_UPPER, OP_ALIGN));
    res(40'hFF_B6A3_7658);
  endtask

  task automatic t_all_sign;
    op(16'hFFFF, 2'b00, mk(1'b0, REF_UPPER, OP_DERIVE));
    rd_chk("exponent", OFS_EXPONENT, 32'h0000_FFF1);
    op(16'hF6D4, 2'b00, mk(1'b0, REF_LOWER, OP_DERIVE));
    rd_chk("exponent", OFS_EXPONENT, 32'h0000_FFED);
    op(16'hFFFF, 2'b00, mk(1'b0, REF_UPPER, OP_ALIGN));
    res(40'hF8_0000_0000);
    // Extension byte no longer matches the middle sign: result overflow with sign kept
    rd_chk("status", OFS_STATUS, 32'h0000_0003);
    op(16'hF6D4, 2'b00, mk(1'b1, REF_LOWER, OP_ALIGN));
    res(40'hFF_B6A0_0000);
    // Upper exponent byte must be ignored by the shift
    wr(OFS_EXPONENT, 32'h0000_7FFD);
    op(16'hF6D4, 2'b00, mk(1'b0, REF_UPPER, OP_ALIGN));
    res(40'hFF_B6A0_0000);
  endtask

  task automatic print_verdict;
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence after 20 reset cycles
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_ovf();
    t_double();
    t_all_sign();
    print_verdict();
  end

  // Watchdog well beyond the hundred or so accesses above
  initial begin
    #40000;
    errors++;
    print_verdict();
  end
endmodule
